// [logic/rscp_defines.svh]
/*
 * Constants of the receiver serial control port: instruction codes,
 * internal register offsets, reset values and scan counts.
 * Assumes byte-wide register addresses on the serial port.
 */
`ifndef RSCP_DEFINES_SVH
`define RSCP_DEFINES_SVH

`define RSCP_INS_WR      8'h02
`define RSCP_INS_RD      8'h03
`define RSCP_INS_FIFO    8'h04
`define RSCP_INS_WRB     8'h01
`define RSCP_INS_RDB     8'h05

`define RSCP_OFS_MODE    8'hF0
`define RSCP_OFS_ATRACE  8'hF1
`define RSCP_OFS_DTRACE  8'hF2
`define RSCP_OFS_CKSUM   8'hF3
`define RSCP_OFS_SN0     8'hF4
`define RSCP_OFS_SN1     8'hF5
`define RSCP_OFS_SN2     8'hF6
`define RSCP_OFS_SN3     8'hF7

`define RSCP_MODE_BIT    0
`define RSCP_RST_BYTE    8'h00
`define RSCP_FIFO_BITS   32
`define RSCP_NUM_CFG     4
`define RSCP_NUM_CHAN    3

`endif

// [logic/rscp_pkg.sv]
/*
 * Types of the receiver serial control port.
 * Assumes rscp_defines.svh is included by the modules that need numbers.
 */
package rscp_pkg;

   typedef enum logic [2:0] {
      ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_FIFO, ST_FSTAT, ST_SKIP
   } rscp_state_e;

   typedef enum logic [1:0] {
      SP_SCAN, SP_SLEEP, SP_RUN
   } rscp_poll_e;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } rscp_wr_s;

endpackage

// [logic/rscp_top.sv]
/*
 * Serial control port slave of the receiver, with write trace, write
 * checksum, serial number, mode select, scan sequencer and payload gate.
 * Assumes serial pins are asynchronous to mclk_i and slow enough
 * (several mclk cycles per serial clock phase) to be oversampled.
 * External registers answer reg_rdata_i combinationally from reg_addr_o.
 */
// What this block does
// - burst read returns successive registers MSB first
// - write frame: instruction, address, one stored byte
// - each write copies address and data to traces
// - traces always hold only latest write
// - burst write stores bytes at incrementing addresses
// - burst write traces track current address and data
// - checksum XORs address and data bytes
// - reading the checksum clears it
// - burst checksum covers start address and data
// - FIFO read: instruction only, then payload bits
// - status byte with valid bit count follows payload
// - write codes 02 single, 01 burst
// - read codes 03 single, 04 FIFO, 05 burst
// - read-only 32-bit serial number as four bytes
// - one bit selects slave or self polling
// - self polling cycles four configs, three channels
// - sleep between scans, wake during a scan enters post-wakeup run
// - matched frame loads payload, unmasked interrupt
// - only payload bits enter the FIFO
// - polling timer runs only in self polling
// - sample input on rising, change output falling
// - single read returns one addressed byte
// - mode bit 1 self polling, 0 slave
`timescale 1ns/10ps
`include "rscp_defines.svh"

module rscp_top import rscp_pkg::*; #(
   parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5660, // arbitrary value
   parameter int          FIFO_BITS     = `RSCP_FIFO_BITS,
   parameter int          NUM_CFG       = `RSCP_NUM_CFG,
   parameter int          NUM_CHAN      = `RSCP_NUM_CHAN
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       chip_select_n_i,
   input  wire logic       serial_clk_i,
   input  wire logic       serial_in_i,
   output logic            serial_out_o,
   output logic            serial_out_oe_n_o,
   output rscp_wr_s        reg_wr_o,
   output logic [7:0]      reg_addr_o,
   output logic            reg_re_o,
   input  wire logic [7:0] reg_rdata_i,
   output logic            fifo_pop_o,
   input  wire logic       fifo_bit_i,
   input  wire logic [7:0] fifo_status_i,
   output logic            operating_mode_select_o,
   output logic            polling_timer_en_o,
   input  wire logic       scan_done_i,
   input  wire logic       poll_tick_i,
   input  wire logic       wake_i,
   output logic [1:0]      scan_cfg_o,
   output logic [1:0]      scan_chan_o,
   output logic            low_power_o,
   output logic            post_wakeup_run_o,
   output logic            wake_irq_o,
   input  wire logic       frame_sync_hit_i,
   input  wire logic       id_ok_i,
   input  wire logic       end_of_message_i,
   input  wire logic       rx_bit_i,
   input  wire logic       rx_bit_valid_i,
   input  wire logic       rx_payload_i,
   input  wire logic       payload_irq_mask_i,
   output logic            fifo_push_o,
   output logic            fifo_data_o,
   output logic            payload_irq_o
);

   logic [1:0]  rst_q;
   logic        rst_n;
   logic [2:0]  s_sck;
   logic [1:0]  s_cs, s_mosi;
   logic        rise, fall, cs_hi, byte_done;
   rscp_state_e st;
   logic        burst, is_wr, fetch, mode, frame_ok;
   logic [2:0]  bit_cnt;
   logic [7:0]  shift, next_shift, addr, tx, fcnt;
   logic [7:0]  addr_trace, data_trace, write_xor_checksum;
   rscp_poll_e  pst;
   // true when a byte address hits a register kept in this block
   function automatic logic is_local(input logic [7:0] a);
      is_local = (a >= `RSCP_OFS_MODE) && (a <= `RSCP_OFS_SN3);
   endfunction

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_sck  <= 3'h0;
         s_cs   <= 2'h3;
         s_mosi <= 2'h0;
      end else begin
         s_sck  <= {s_sck[1:0], serial_clk_i};
         s_cs   <= {s_cs[0], chip_select_n_i};
         s_mosi <= {s_mosi[0], serial_in_i};
      end
   end

   assign rise       = s_sck[1] & ~s_sck[2] & ~s_cs[1];
   assign fall       = ~s_sck[1] & s_sck[2] & ~s_cs[1];
   assign cs_hi      = s_cs[1];
   assign next_shift = {shift[6:0], s_mosi[1]};
   assign byte_done  = rise && (bit_cnt == 3'h7);

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 3'h0;
         shift   <= `RSCP_RST_BYTE;
      end else if (cs_hi) begin
         bit_cnt <= 3'h0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         shift   <= next_shift;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st    <= ST_CMD;
         burst <= 1'b0;
         is_wr <= 1'b0;
         addr  <= `RSCP_RST_BYTE;
         fcnt  <= 8'h00;
      end else if (cs_hi) begin
         st    <= ST_CMD;
         fcnt  <= 8'h00;
      end else if (rise) begin
         case (st)
            ST_CMD: begin
               if (byte_done) begin
                  burst <= (next_shift == `RSCP_INS_WRB) || (next_shift == `RSCP_INS_RDB);
                  is_wr <= (next_shift == `RSCP_INS_WR) || (next_shift == `RSCP_INS_WRB);
                  fcnt  <= 8'h00;
                  case (next_shift)
                     `RSCP_INS_WR, `RSCP_INS_WRB,
                     `RSCP_INS_RD, `RSCP_INS_RDB: st <= ST_ADDR;
                     // no address byte for FIFO read
                     `RSCP_INS_FIFO: st <= ST_FIFO;
                     default: st <= ST_SKIP;
                  endcase
               end
            end
            ST_ADDR: begin
               if (byte_done) begin
                  addr <= next_shift;
                  st   <= is_wr ? ST_WDATA : ST_RDATA;
               end
            end
            ST_WDATA, ST_RDATA: begin
               if (byte_done) begin
                  if (burst) begin
                     addr <= addr + 8'h01;
                  end else begin
                     st <= ST_CMD;
                  end
               end
            end
            ST_FIFO: begin
               fcnt <= fcnt + 8'h01;
               if (fcnt == 8'(FIFO_BITS - 1)) begin
                  st <= ST_FSTAT;
               end
            end
            ST_FSTAT: begin
               if (byte_done) begin
                  st <= ST_CMD;
               end
            end
            default: st <= ST_SKIP;
         endcase
      end
   end

   // a byte to send is fetched one cycle after the byte that asks for it
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         fetch <= 1'b0;
      end else begin
         fetch <= !cs_hi && (((st == ST_ADDR) && !is_wr && byte_done)
                  || ((st == ST_RDATA) && burst && byte_done)
                  || ((st == ST_FIFO) && rise && (fcnt == 8'(FIFO_BITS - 1))));
      end
   end

   assign reg_addr_o = addr;
   assign reg_re_o   = fetch && (st == ST_RDATA) && !is_local(addr);
   assign fifo_pop_o = fall && (st == ST_FIFO);

   // output changes on falling edges only
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx           <= `RSCP_RST_BYTE;
         serial_out_o <= 1'b0;
      end else if (fetch && (st == ST_FSTAT)) begin
         tx <= fifo_status_i;
      end else if (fetch) begin
         case (addr)
            `RSCP_OFS_MODE:   tx <= {7'h00, mode};
            `RSCP_OFS_ATRACE: tx <= addr_trace;
            `RSCP_OFS_DTRACE: tx <= data_trace;
            `RSCP_OFS_CKSUM:  tx <= write_xor_checksum;
            `RSCP_OFS_SN0:    tx <= SERIAL_NUMBER[7:0];
            `RSCP_OFS_SN1:    tx <= SERIAL_NUMBER[15:8];
            `RSCP_OFS_SN2:    tx <= SERIAL_NUMBER[23:16];
            `RSCP_OFS_SN3:    tx <= SERIAL_NUMBER[31:24];
            default:          tx <= reg_rdata_i;
         endcase
      end else if (fall && (st == ST_FIFO)) begin
         serial_out_o <= fifo_bit_i;
      end else if (fall && ((st == ST_RDATA) || (st == ST_FSTAT))) begin
         serial_out_o <= tx[7];
         tx           <= {tx[6:0], 1'b0};
      end
   end

   assign serial_out_oe_n_o = cs_hi;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_wr_o   <= '0;
         addr_trace <= `RSCP_RST_BYTE;
         data_trace <= `RSCP_RST_BYTE;
      end else begin
         reg_wr_o.we <= 1'b0;
         if (!cs_hi && (st == ST_WDATA) && byte_done) begin
            reg_wr_o.we   <= !is_local(addr);
            reg_wr_o.addr <= addr;
            reg_wr_o.data <= next_shift;
            addr_trace    <= addr;
            data_trace    <= next_shift;
         end
      end
   end

   // checksum, an update wins over the read clear
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         write_xor_checksum <= `RSCP_RST_BYTE;
      end else if (!cs_hi && byte_done && is_wr && ((st == ST_ADDR) || (st == ST_WDATA))) begin
         write_xor_checksum <= write_xor_checksum ^ next_shift;
      end else if (fetch && (st == ST_RDATA) && (addr == `RSCP_OFS_CKSUM)) begin
         write_xor_checksum <= `RSCP_RST_BYTE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mode <= 1'b0;
      end else if (!cs_hi && (st == ST_WDATA) && byte_done && (addr == `RSCP_OFS_MODE)) begin
         mode <= next_shift[`RSCP_MODE_BIT];
      end
   end

   assign operating_mode_select_o = mode;
   assign polling_timer_en_o      = mode && (pst != SP_RUN);
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pst         <= SP_SCAN;
         scan_cfg_o  <= 2'h0;
         scan_chan_o <= 2'h0;
         wake_irq_o  <= 1'b0;
      end else begin
         wake_irq_o <= 1'b0;
         if (!mode) begin
            pst         <= SP_SCAN;
            scan_cfg_o  <= 2'h0;
            scan_chan_o <= 2'h0;
         end else begin
            case (pst)
               SP_SCAN: begin
                  if (wake_i) begin
                     pst        <= SP_RUN;
                     wake_irq_o <= 1'b1;
                  end else if (scan_done_i) begin
                     pst <= SP_SLEEP;
                     if (scan_chan_o == 2'(NUM_CHAN - 1)) begin
                        scan_chan_o <= 2'h0;
                        scan_cfg_o <= (scan_cfg_o == 2'(NUM_CFG - 1)) ? 2'h0 : scan_cfg_o + 2'h1;
                     end else begin
                        scan_chan_o <= scan_chan_o + 2'h1;
                     end
                  end
               end
               SP_SLEEP: begin
                  if (poll_tick_i) begin
                     pst <= SP_SCAN;
                  end
               end
               SP_RUN: pst <= SP_RUN;
               default: pst <= SP_SCAN;
            endcase
         end
      end
   end

   assign low_power_o       = mode && (pst == SP_SLEEP);
   assign post_wakeup_run_o = mode && (pst == SP_RUN);
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         frame_ok      <= 1'b0;
         payload_irq_o <= 1'b0;
         fifo_push_o   <= 1'b0;
         fifo_data_o   <= 1'b0;
      end else begin
         payload_irq_o <= frame_sync_hit_i && id_ok_i && !frame_ok && !payload_irq_mask_i;
         if (frame_sync_hit_i && id_ok_i) begin
            frame_ok <= 1'b1;
         end else if (end_of_message_i) begin
            frame_ok <= 1'b0;
         end
         fifo_push_o <= frame_ok && rx_bit_valid_i && rx_payload_i;
         fifo_data_o <= rx_bit_i;
      end
   end
   default clocking rscp_cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n);
   cs_abort_a: assert property (cs_hi |=> (st == ST_CMD) && (bit_cnt == 3'h0))
      else $error("frame not aborted by deselect");
   trace_addr_a: assert property ($rose(reg_wr_o.we)
      |-> (addr_trace == reg_wr_o.addr) && (data_trace == reg_wr_o.data))
      else $error("trace registers do not match write");
   burst_step_a: assert property ((!cs_hi && (st == ST_WDATA) && burst && byte_done)
      |=> (addr == $past(addr) + 8'h01))
      else $error("burst address not incremented");
   cksum_clr_a: assert property ((fetch && (st == ST_RDATA) && !byte_done
      && (addr == `RSCP_OFS_CKSUM)) |=> (write_xor_checksum == 8'h00)
      && (tx == $past(write_xor_checksum)))
      else $error("checksum not cleared by read");
   cmd_decode_a: assert property ((!cs_hi && (st == ST_CMD) && byte_done
      && (next_shift == `RSCP_INS_FIFO)) |=> (st == ST_FIFO) ##1 (fcnt == 8'h00))
      else $error("FIFO instruction not decoded");
   fifo_only_a: assert property (fifo_push_o |-> $past(rx_payload_i) && $past(frame_ok))
      else $error("non-payload bit pushed");
   slave_quiet_a: assert property (!mode |-> !polling_timer_en_o && !low_power_o
      && !post_wakeup_run_o)
      else $error("polling active in slave mode");
   out_edge_a: assert property ($changed(serial_out_o) |-> $past(fall))
      else $error("serial output changed off a falling edge");
endmodule

// [tb/rscp_host_model.sv]
/*
 * Serial bus master model standing in for the application controller.
 * Assumes mclk_i at 4 ns; one serial clock bit lasts 40 mclk cycles.
 */
`timescale 1ns/10ps

module rscp_host_model (
   input  wire logic mclk_i,
   input  wire logic sdo_i,
   output logic      csn_o,
   output logic      sclk_o,
   output logic      sdi_o
);
   localparam int HALF = 20;

   initial begin
      csn_o = 1'h1;
      sclk_o = 1'h0;
      sdi_o = 1'h0;
   end

   task automatic frame_begin();
      @(negedge mclk_i);
      csn_o = 1'h0;
      repeat (HALF) @(negedge mclk_i);
   endtask

   task automatic frame_end();
      repeat (HALF) @(negedge mclk_i);
      csn_o = 1'h1;
      sdi_o = ~sdi_o;
      repeat (2 * HALF) @(negedge mclk_i);
   endtask

   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < nb; i++) begin
         sdi_o = tx[7 - i];
         repeat (HALF) @(negedge mclk_i);
         sclk_o = 1'h1;
         rx[7 - i] = sdo_i;
         repeat (HALF) @(negedge mclk_i);
         sclk_o = 1'h0;
      end
   endtask
endmodule

// [tb/tb_top.sv]
/*
 * Bench of rscp_top: a behavioural port model compared at every result.
 * Assumes rscp_host_model as serial master; the bench owns external registers.
 */
`timescale 1ns/10ps
`include "rscp_defines.svh"

module tb_top import rscp_pkg::*; ;
   localparam logic [31:0] SN = 32'h3C5A_9E6E; // arbitrary value
   logic        mclk = 1'h0;
   logic        rst_n = 1'h0;
   logic        csn, sclk, serial_in, serial_out, oe_n, re, pop, fbit, md, ten, lp, pwr;
   logic        wirq, push, pdat, pirq, done, tick, wake, hit, idk, end_of_message, rxb, rxv, rxp, msk;
   logic [1:0]  cfg, chn, mc, mh;
   logic [7:0]  addr, rd, stat, rx, a, d, atr, dtr, ck;
   logic [7:0]  ext [256];
   logic [7:0]  mem [256];
   logic [31:0] pay;
   rscp_wr_s    wr;
   logic        pq [$];
   int          idx, n_wr, n_wake, n_pirq, n_re, n_errors, num_checks;
   integer      seed = 64;

   assign rd = ext[addr];
   assign fbit = pay[31 - idx];

   always #2 mclk = ~mclk;

   rscp_host_model i_host (.mclk_i(mclk), .sdo_i(serial_out), .csn_o(csn), .sclk_o(sclk), .sdi_o(serial_in));

   rscp_top #(.SERIAL_NUMBER(SN)) i_dut (
      .mclk_i(mclk), .rst_n_i(rst_n), .chip_select_n_i(csn), .serial_clk_i(sclk),
      .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_n_o(oe_n), .reg_wr_o(wr),
      .reg_addr_o(addr), .reg_re_o(re), .reg_rdata_i(rd), .fifo_pop_o(pop),
      .fifo_bit_i(fbit), .fifo_status_i(stat), .operating_mode_select_o(md),
      .polling_timer_en_o(ten), .scan_done_i(done), .poll_tick_i(tick), .wake_i(wake),
      .scan_cfg_o(cfg), .scan_chan_o(chn), .low_power_o(lp), .post_wakeup_run_o(pwr),
      .wake_irq_o(wirq), .frame_sync_hit_i(hit), .id_ok_i(idk), .end_of_message_i(end_of_message),
      .rx_bit_i(rxb), .rx_bit_valid_i(rxv), .rx_payload_i(rxp), .payload_irq_mask_i(msk),
      .fifo_push_o(push), .fifo_data_o(pdat), .payload_irq_o(pirq)
   );

   always @(posedge mclk) begin
      if (wr.we === 1'h1) begin
         ext[wr.addr] <= wr.data;
         n_wr <= n_wr + 1;
      end
      if (pop === 1'h1) idx <= idx + 1;
      if (push === 1'h1) pq.push_back(pdat);
      if (wirq === 1'h1) n_wake <= n_wake + 1;
      if (re === 1'h1) n_re <= n_re + 1;
      if (pirq === 1'h1) n_pirq <= n_pirq + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   function automatic void mw(input logic [7:0] wa, input logic [7:0] wd);
      if (wa < `RSCP_OFS_MODE) mem[wa] = wd;
      atr = wa;
      dtr = wd;
   endfunction

   function automatic logic [7:0] er(input logic [7:0] ra);
      logic [7:0] v;
      v = (ra >= `RSCP_OFS_SN0) ? SN[8 * (ra - `RSCP_OFS_SN0) +: 8] : mem[ra];
      if (ra == `RSCP_OFS_ATRACE) v = atr;
      if (ra == `RSCP_OFS_DTRACE) v = dtr;
      if (ra == `RSCP_OFS_CKSUM) begin
         v = ck;
         ck = 8'h00;
      end
      return v;
   endfunction

   task automatic sb(input logic [7:0] tx);
      i_host.xfer(tx, 8, rx);
   endtask

   task automatic w1(input logic [7:0] wa, input logic [7:0] wd);
      sb(`RSCP_INS_WR);
      sb(wa);
      sb(wd);
      mw(wa, wd);
      ck ^= wa ^ wd;
   endtask

   task automatic r1(input logic [7:0] ra);
      sb(`RSCP_INS_RD);
      sb(ra);
      sb(8'h00);
      check(oe_n, 1'h0);
      check(rx, er(ra));
   endtask

   task automatic br(input logic [7:0] s, input int n);
      sb(`RSCP_INS_RDB);
      sb(s);
      for (int k = 0; k < n; k++) begin
         sb(8'h00);
         check(rx, er(s + 8'(k)));
      end
   endtask

   task automatic bw(input logic [7:0] s, input int n);
      logic [7:0] v;
      sb(`RSCP_INS_WRB);
      sb(s);
      ck ^= s;
      for (int k = 0; k < n; k++) begin
         v = 8'($random(seed));
         sb(v);
         mw(s + 8'(k), v);
         ck ^= v;
      end
   endtask

   task automatic pulse(input logic [2:0] m);
      @(negedge mclk);
      {wake, tick, done} = m;
      @(negedge mclk);
      {wake, tick, done} = 3'h0;
      repeat (3) @(negedge mclk);
   endtask

   task automatic gate(input logic m, input logic ok);
      int np;
      np = n_pirq;
      d = 8'($random(seed));
      pq.delete();
      @(negedge mclk);
      msk = m;
      hit = 1'h1;
      idk = ok;
      @(negedge mclk);
      hit = 1'h0;
      idk = 1'h0;
      for (int i = 0; i < 10; i++) begin
         rxv = 1'h1;
         rxp = (i >= 2);
         rxb = (i < 2) ? 1'h1 : d[9 - i];
         @(negedge mclk);
      end
      rxv = 1'h0;
      end_of_message = 1'h1;
      @(negedge mclk);
      end_of_message = 1'h0;
      rxv = 1'h1;
      repeat (2) @(negedge mclk);
      rxv = 1'h0;
      rxp = 1'h0;
      repeat (3) @(negedge mclk);
      check(pq.size(), ok ? 8 : 0);
      for (int i = 0; i < pq.size(); i++) check(pq[i], d[7 - i]);
      check(n_pirq - np, (ok && !m) ? 1 : 0);
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      {done, tick, wake, hit, idk, end_of_message, rxb, rxv, rxp, msk} = 10'h000;
      {idx, n_wr, n_wake, n_pirq, n_re, n_errors, num_checks} = '0;
      pay = 32'h0;
      stat = 8'h00;
      {atr, dtr, ck, mc, mh} = '0;
      for (int i = 0; i < 256; i++) begin
         ext[i] = 8'($random(seed));
         mem[i] = ext[i];
      end
      repeat (6) @(negedge mclk);
      check({oe_n, wr.we, push, pirq, md}, 5'h10);
      rst_n = 1'h1;
      repeat (10) @(negedge mclk);
      i_host.frame_begin();
      br(`RSCP_OFS_SN0, 4);
      i_host.frame_end();
      i_host.frame_begin();
      br(`RSCP_OFS_ATRACE, 3);
      i_host.frame_end();
      a = 8'($random(seed)) & 8'h7F;
      i_host.frame_begin();
      w1(a, 8'($random(seed)));
      r1(a);
      r1(`RSCP_OFS_ATRACE);
      w1(a ^ 8'h21, 8'($random(seed)));
      r1(`RSCP_OFS_ATRACE);
      r1(`RSCP_OFS_DTRACE);
      r1(`RSCP_OFS_CKSUM);
      r1(`RSCP_OFS_CKSUM);
      i_host.frame_end();
      i_host.frame_begin();
      bw(8'h80 | (8'($random(seed)) & 8'h3F), 4);
      i_host.frame_end();
      i_host.frame_begin();
      br(atr - 8'h03, 4);
      i_host.frame_end();
      i_host.frame_begin();
      br(`RSCP_OFS_ATRACE, 3);
      i_host.frame_end();
      i_host.frame_begin();
      sb(`RSCP_INS_WR);
      sb(a);
      i_host.xfer(~mem[a], 5, rx);
      i_host.frame_end();
      i_host.frame_begin();
      sb(8'h07);
      sb(`RSCP_INS_WR);
      sb(a);
      sb(~mem[a]);
      i_host.frame_end();
      i_host.frame_begin();
      r1(a);
      i_host.frame_end();
      check(n_wr, 6);
      check(n_re, 8);
      pay = $random(seed);
      stat = 8'($random(seed));
      i_host.frame_begin();
      sb(`RSCP_INS_FIFO);
      for (int k = 0; k < 4; k++) begin
         sb(8'h00);
         check(rx, pay[31 - 8 * k -: 8]);
      end
      sb(8'h00);
      check(rx, stat);
      i_host.frame_end();
      check(idx, 32);
      pulse(3'h1);
      check({md, ten, lp}, 3'h0);
      i_host.frame_begin();
      w1(`RSCP_OFS_MODE, 8'h01);
      i_host.frame_end();
      check({md, ten, lp}, 3'h6);
      for (int k = 0; k < 13; k++) begin
         check({cfg, chn}, {mc, mh});
         pulse(3'h1);
         check(lp, 1'h1);
         pulse(3'h2);
         check(lp, 1'h0);
         mh = (mh == 2'h2) ? 2'h0 : mh + 2'h1;
         if (mh == 2'h0) mc = mc + 2'h1;
      end
      pulse(3'h4);
      check({pwr, ten, n_wake[1:0]}, 4'h9);
      i_host.frame_begin();
      w1(`RSCP_OFS_MODE, 8'h00);
      i_host.frame_end();
      check({md, ten, pwr, cfg, chn}, 7'h00);
      gate(1'h0, 1'h1);
      gate(1'h1, 1'h1);
      gate(1'h0, 1'h0);
      print_verdict();
   end

   initial begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      print_verdict();
   end
endmodule
